// ==== core/light_sensor_dev.sv ====
// light sensor device end: registers, integration timing, threshold interrupt
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module light_sensor_dev #(
  parameter int INTEG_SHORT_CYC = light_sensor_pkg::INTEG_SHORT_CYC,
  parameter int INTEG_MID_CYC   = light_sensor_pkg::INTEG_MID_CYC,
  parameter int INTEG_LONG_CYC  = light_sensor_pkg::INTEG_LONG_CYC
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // link to host
  als_link_if.dev          link,
  // analog front end
  input  wire logic [15:0] adcCh0,
  input  wire logic [15:0] adcCh1,
  output logic             gainHigh,
  output logic             integrating,
  output logic             convDone
);

  localparam int CW = light_sensor_pkg::INTEG_CNT_W;

  logic [7:0]    control_q;
  logic [7:0]    timing_q;
  logic [7:0]    intCtl_q;
  logic [15:0]   thLow_q;
  logic [15:0]   thHigh_q;
  logic [15:0]   data0_q;
  logic [15:0]   data1_q;
  logic [CW-1:0] integCnt_q;
  logic          integ_q;
  logic          done_q;
  logic          gain_q;
  logic [3:0]    persistCnt_q;
  logic          intPend_q;
  logic          intOe_q;
  logic          rspValid_q;
  logic          rspAck_q;
  logic [15:0]   rspData_q;

  // byte a write delivers to register tgt: {hit, data}
  function automatic logic [8:0] wrByte(input logic [3:0] a, input logic word,
                                        input logic [15:0] d, input logic [3:0] tgt);
    logic hitLo;
    logic hitHi;
    hitLo = (a == tgt);
    hitHi = word && (4'(a + 4'h1) == tgt);
    if (hitLo)
      wrByte = {1'b1, d[7:0]};
    else if (hitHi)
      wrByte = {1'b1, d[15:8]};
    else
      wrByte = {1'b0, 8'h00};
  endfunction

  // read decode; unmapped addresses read as zero
  function automatic logic [7:0] rdByte(input logic [3:0] a, input logic [7:0] ctl,
                                        input logic [7:0] tim, input logic [7:0] ic,
                                        input logic [15:0] tl, input logic [15:0] th,
                                        input logic [15:0] d0, input logic [15:0] d1);
    case (a)
      light_sensor_pkg::ADDR_CONTROL: rdByte = ctl;
      light_sensor_pkg::ADDR_TIMING:  rdByte = tim;
      light_sensor_pkg::ADDR_THLO_L:  rdByte = tl[7:0];
      light_sensor_pkg::ADDR_THLO_H:  rdByte = tl[15:8];
      light_sensor_pkg::ADDR_THHI_L:  rdByte = th[7:0];
      light_sensor_pkg::ADDR_THHI_H:  rdByte = th[15:8];
      light_sensor_pkg::ADDR_INTCTL:  rdByte = ic;
      light_sensor_pkg::ADDR_ID:      rdByte = light_sensor_pkg::ID_VALUE;
      light_sensor_pkg::ADDR_DATA0_L: rdByte = d0[7:0];
      light_sensor_pkg::ADDR_DATA0_H: rdByte = d0[15:8];
      light_sensor_pkg::ADDR_DATA1_L: rdByte = d1[7:0];
      light_sensor_pkg::ADDR_DATA1_H: rdByte = d1[15:8];
      default:                        rdByte = 8'h00;
    endcase
  endfunction

  // request decode
  wire       reqTake = ce && link.reqValid;
  wire       isWrite = reqTake && (link.reqKind == light_sensor_pkg::REQ_WRITE)
                       && link.reqCmd[light_sensor_pkg::CMD_SEL_BIT];
  wire       isRead  = reqTake && (link.reqKind == light_sensor_pkg::REQ_READ)
                       && link.reqCmd[light_sensor_pkg::CMD_SEL_BIT];
  wire       isAlert = reqTake && (link.reqKind == light_sensor_pkg::REQ_ALERT);
  wire [3:0] regAddr = link.reqCmd[3:0];
  wire       wordOp  = link.reqCmd[light_sensor_pkg::CMD_WORD_BIT];

  // per-register write hits
  wire [8:0] wCtl  = wrByte(regAddr, wordOp, link.reqData, light_sensor_pkg::ADDR_CONTROL);
  wire [8:0] wTim  = wrByte(regAddr, wordOp, link.reqData, light_sensor_pkg::ADDR_TIMING);
  wire [8:0] wIc   = wrByte(regAddr, wordOp, link.reqData, light_sensor_pkg::ADDR_INTCTL);
  wire [8:0] wTlL  = wrByte(regAddr, wordOp, link.reqData, light_sensor_pkg::ADDR_THLO_L);
  wire [8:0] wTlH  = wrByte(regAddr, wordOp, link.reqData, light_sensor_pkg::ADDR_THLO_H);
  wire [8:0] wThL  = wrByte(regAddr, wordOp, link.reqData, light_sensor_pkg::ADDR_THHI_L);
  wire [8:0] wThH  = wrByte(regAddr, wordOp, link.reqData, light_sensor_pkg::ADDR_THHI_H);
  wire       ctlWr = isWrite && wCtl[8];
  wire       timWr = isWrite && wTim[8];
  wire       icWr  = isWrite && wIc[8];

  // integration timing
  wire [1:0]    integSel   = timing_q[1:0];
  wire          powered    = (control_q[1:0] == light_sensor_pkg::POWER_ON);
  wire          manualMode = (integSel == light_sensor_pkg::INTEG_MANUAL);
  wire [CW-1:0] integLast  =
    (integSel == light_sensor_pkg::INTEG_SHORT) ? CW'(INTEG_SHORT_CYC - 1) :
    (integSel == light_sensor_pkg::INTEG_MID)   ? CW'(INTEG_MID_CYC - 1) :
                                                  CW'(INTEG_LONG_CYC - 1);
  wire autoEnd   = powered && !manualMode && (integCnt_q == integLast);
  wire manualEnd = powered && manualMode && integ_q
                   && !timing_q[light_sensor_pkg::TIM_MANUAL_BIT];
  wire convEnd   = autoEnd || manualEnd;
  wire integOn   = powered && (!manualMode
                   || timing_q[light_sensor_pkg::TIM_MANUAL_BIT]);

  // threshold test on channel 0 only
  wire [1:0] style     = intCtl_q[5:4];
  wire [3:0] persist   = intCtl_q[3:0];
  wire       outWindow = (adcCh0 > thHigh_q) || (adcCh0 < thLow_q);
  wire [3:0] cntNext   = persistCnt_q + 4'h1;
  wire       fire      = convEnd && ((persist == 4'h0)
                         || (outWindow && (cntNext >= persist)));

  // interrupt set and clear; set wins over clear
  wire testSet  = icWr && (wIc[5:4] == light_sensor_pkg::STYLE_TEST);
  wire intSet   = (fire && (style != light_sensor_pkg::STYLE_OFF)) || testSet;
  wire lvlClear = isWrite && link.reqCmd[light_sensor_pkg::CMD_CLEAR_BIT]
                  && (style == light_sensor_pkg::STYLE_LEVEL);
  wire araWin   = isAlert && intPend_q && style[1];
  wire intPendD = intSet || (intPend_q && !(lvlClear || araWin));
  // style zero hides a pending interrupt from the pin; it shows again once re-enabled
  wire [1:0] styleNext = icWr ? wIc[5:4] : style;
  wire       intOeD    = intPendD && (styleNext != light_sensor_pkg::STYLE_OFF);

  // read answer: word reads return address a in low byte, a+1 in high
  wire [7:0] rdLo = rdByte(regAddr, control_q, timing_q, intCtl_q, thLow_q, thHigh_q,
                           data0_q, data1_q);
  wire [7:0] rdHi = rdByte(4'(regAddr + 4'h1), control_q, timing_q, intCtl_q, thLow_q,
                           thHigh_q, data0_q, data1_q);
  wire [15:0] rspDataD = isAlert ? {8'h00, light_sensor_pkg::DEV_ADDR, 1'b0} :
                         (wordOp ? {rdHi, rdLo} : {8'h00, rdLo});

  // configuration registers, defaults loaded under reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_q <= light_sensor_pkg::CONTROL_RST;
      timing_q  <= light_sensor_pkg::TIMING_RST;
      intCtl_q  <= light_sensor_pkg::INTCTL_RST;
      thLow_q   <= light_sensor_pkg::THRESH_RST;
      thHigh_q  <= light_sensor_pkg::THRESH_RST;
    end
    else if (ce)
    begin
      if (ctlWr) control_q <= wCtl[7:0];
      if (timWr) timing_q <= wTim[7:0];
      if (icWr) intCtl_q <= {2'b00, wIc[5:0]};      // reserved bits kept zero
      if (isWrite && wTlL[8]) thLow_q[7:0] <= wTlL[7:0];
      if (isWrite && wTlH[8]) thLow_q[15:8] <= wTlH[7:0];
      if (isWrite && wThL[8]) thHigh_q[7:0] <= wThL[7:0];
      if (isWrite && wThH[8]) thHigh_q[15:8] <= wThH[7:0];
    end
  end

  // integration counter; a timing write restarts the cycle so a new length applies cleanly
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      integCnt_q <= '0;
      integ_q    <= 1'b0;
      done_q     <= 1'b0;
      gain_q     <= 1'b0;
      data0_q    <= light_sensor_pkg::DATA_RST;
      data1_q    <= light_sensor_pkg::DATA_RST;
    end
    else if (ce)
    begin
      integCnt_q <= (convEnd || timWr || !integOn) ? '0 : CW'(integCnt_q + 1'b1);
      integ_q    <= integOn;
      done_q     <= convEnd;
      gain_q     <= timing_q[light_sensor_pkg::TIM_GAIN_BIT];
      if (convEnd)
      begin
        data0_q <= adcCh0;
        data1_q <= adcCh1;
      end
    end
  end

  // persistence filter and pending interrupt
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      persistCnt_q <= 4'h0;
      intPend_q    <= 1'b0;
      intOe_q      <= 1'b0;
    end
    else if (ce)
    begin
      if (icWr || (convEnd && (!outWindow || fire)))
        persistCnt_q <= 4'h0;
      else if (convEnd)
        persistCnt_q <= cntNext;
      intPend_q <= intPendD;
      intOe_q   <= intOeD;
    end
  end

  // one response per request, the cycle after it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rspValid_q <= 1'b0;
      rspAck_q   <= 1'b0;
      rspData_q  <= 16'h0000;
    end
    else if (ce)
    begin
      rspValid_q <= reqTake;
      rspAck_q   <= isWrite || isRead || araWin;
      if (reqTake) rspData_q <= rspDataD;
    end
  end

  assign link.rspValid  = rspValid_q;
  assign link.rspAck    = rspAck_q;
  assign link.rspData   = rspData_q;
  assign link.devIntOut = 1'b0;                     // open drain pulls low only
  assign link.devIntOe  = intOe_q;
  assign gainHigh       = gain_q;
  assign integrating    = integ_q;
  assign convDone       = done_q;

endmodule // light_sensor_dev
`default_nettype wire

// ==== core/light_sensor_pkg.sv ====
// shared constants and types for the light sensor device and its host controller
package light_sensor_pkg;

  // clock and integration times
  localparam int CLK_MHZ        = 10;
  localparam int INTEG_SHORT_US = 13700;   // 13.7 ms
  localparam int INTEG_MID_US   = 101000;  // 101 ms
  localparam int INTEG_LONG_US  = 402000;  // 402 ms
  localparam int INTEG_SHORT_CYC = INTEG_SHORT_US * CLK_MHZ;
  localparam int INTEG_MID_CYC   = INTEG_MID_US * CLK_MHZ;
  localparam int INTEG_LONG_CYC  = INTEG_LONG_US * CLK_MHZ;
  localparam int INTEG_CNT_W     = 23;

  // device register addresses (command byte low nibble)
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_TIMING  = 4'h1;
  localparam logic [3:0] ADDR_THLO_L  = 4'h2;
  localparam logic [3:0] ADDR_THLO_H  = 4'h3;
  localparam logic [3:0] ADDR_THHI_L  = 4'h4;
  localparam logic [3:0] ADDR_THHI_H  = 4'h5;
  localparam logic [3:0] ADDR_INTCTL  = 4'h6;
  localparam logic [3:0] ADDR_ID      = 4'hA;
  localparam logic [3:0] ADDR_DATA0_L = 4'hC;
  localparam logic [3:0] ADDR_DATA0_H = 4'hD;
  localparam logic [3:0] ADDR_DATA1_L = 4'hE;
  localparam logic [3:0] ADDR_DATA1_H = 4'hF;

  // command byte fields
  localparam int CMD_SEL_BIT   = 7;
  localparam int CMD_CLEAR_BIT = 6;
  localparam int CMD_WORD_BIT  = 5;

  // register fields
  localparam int         TIM_GAIN_BIT   = 4;
  localparam int         TIM_MANUAL_BIT = 3;
  localparam logic [1:0] INTEG_SHORT    = 2'h0;
  localparam logic [1:0] INTEG_MID      = 2'h1;
  localparam logic [1:0] INTEG_LONG     = 2'h2;
  localparam logic [1:0] INTEG_MANUAL   = 2'h3;
  localparam logic [1:0] POWER_ON       = 2'h3;
  localparam logic [1:0] STYLE_OFF      = 2'h0;
  localparam logic [1:0] STYLE_LEVEL    = 2'h1;
  localparam logic [1:0] STYLE_ALERT    = 2'h2;
  localparam logic [1:0] STYLE_TEST     = 2'h3;

  // reset values
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  TIMING_RST  = 8'h02;
  localparam logic [7:0]  INTCTL_RST  = 8'h00;
  localparam logic [15:0] THRESH_RST  = 16'h0000;
  localparam logic [15:0] DATA_RST    = 16'h0000;

  // bus address answered during an alert response, and an arbitrary id value
  localparam logic [6:0] DEV_ADDR = 7'h39;
  localparam logic [7:0] ID_VALUE = 8'h5A;  // arbitrary value

  // link request kinds
  typedef enum logic [1:0] {
    REQ_WRITE = 2'h0,
    REQ_READ  = 2'h1,
    REQ_ALERT = 2'h2
  } req_kind_e;

  // host controller register offsets
  localparam logic [3:0] HOST_REQ    = 4'h0;
  localparam logic [3:0] HOST_WDATA  = 4'h1;
  localparam logic [3:0] HOST_RESULT = 4'h2;
  localparam logic [3:0] HOST_STATUS = 4'h3;

  // host controller states
  typedef enum logic [2:0] {
    H_IDLE  = 3'b001,
    H_ISSUE = 3'b010,
    H_WAIT  = 3'b100
  } host_state_e;

endpackage

// ==== core/als_link_if.sv ====
// link between the light sensor device and its host controller
`timescale 1ns/1ps
`default_nettype none
interface als_link_if;
  logic                          reqValid;
  light_sensor_pkg::req_kind_e   reqKind;
  logic [7:0]                    reqCmd;
  logic [15:0]                   reqData;
  logic                          rspValid;
  logic                          rspAck;
  logic [15:0]                   rspData;
  logic                          devIntOut;
  logic                          devIntOe;
  logic                          intLineN;

  // open-drain interrupt line with pull-up
  assign intLineN = devIntOe ? devIntOut : 1'b1;

  modport dev (
    input  reqValid, reqKind, reqCmd, reqData,
    output rspValid, rspAck, rspData, devIntOut, devIntOe
  );
  modport host (
    output reqValid, reqKind, reqCmd, reqData,
    input  rspValid, rspAck, rspData, intLineN
  );
endinterface
`default_nettype wire

// ==== core/light_sensor_host.sv ====
// host controller end: software register port turned into link transactions
`timescale 1ns/1ps
`default_nettype none
module light_sensor_host (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // software register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic [15:0]      rdData,
  // link to device
  als_link_if.host         link
);

  light_sensor_pkg::host_state_e state_q;
  light_sensor_pkg::host_state_e state_d;
  light_sensor_pkg::req_kind_e   kind_q;
  logic [7:0]                    cmd_q;
  logic [15:0]                   wdata_q;
  logic [15:0]                   result_q;
  logic                          ack_q;
  logic [15:0]                   rdData_q;
  logic                          reqValid_q;

  // software decode; launches while busy are ignored
  wire busy      = (state_q != light_sensor_pkg::H_IDLE);
  wire launch    = ce && wrStb && (addr == light_sensor_pkg::HOST_REQ) && !busy;
  wire wdataWr   = ce && wrStb && (addr == light_sensor_pkg::HOST_WDATA);
  wire intActive = !link.intLineN;
  wire [15:0] status   = {13'h0000, intActive, ack_q, busy};
  wire [15:0] rdSelect = (addr == light_sensor_pkg::HOST_REQ)    ? {6'h00, kind_q, cmd_q} :
                         (addr == light_sensor_pkg::HOST_WDATA)  ? wdata_q :
                         (addr == light_sensor_pkg::HOST_RESULT) ? result_q :
                         (addr == light_sensor_pkg::HOST_STATUS) ? status : 16'h0000;

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      light_sensor_pkg::H_IDLE:  if (launch) state_d = light_sensor_pkg::H_ISSUE;
      light_sensor_pkg::H_ISSUE: state_d = light_sensor_pkg::H_WAIT;
      light_sensor_pkg::H_WAIT:  if (link.rspValid) state_d = light_sensor_pkg::H_IDLE;
      default:                   state_d = light_sensor_pkg::H_IDLE;
    endcase
  end

  // request registers: command byte, kind and word data go out as written
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= light_sensor_pkg::H_IDLE;
      kind_q     <= light_sensor_pkg::REQ_WRITE;
      cmd_q      <= 8'h00;
      wdata_q    <= 16'h0000;
      reqValid_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q    <= state_d;
      reqValid_q <= launch;
      if (launch)
      begin
        kind_q <= light_sensor_pkg::req_kind_e'(wrData[9:8]);
        cmd_q  <= wrData[7:0];
      end
      if (wdataWr) wdata_q <= wrData;                // both bytes at once, whole word in one write
    end
  end

  // answer capture and software read data
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_q <= 16'h0000;
      ack_q    <= 1'b0;
      rdData_q <= 16'h0000;
    end
    else if (ce)
    begin
      if ((state_q == light_sensor_pkg::H_WAIT) && link.rspValid)
      begin
        result_q <= link.rspData;
        ack_q    <= link.rspAck;
      end
      rdData_q <= rdStb ? rdSelect : 16'h0000;
    end
  end

  assign link.reqValid = reqValid_q;
  assign link.reqKind  = kind_q;
  assign link.reqCmd   = cmd_q;
  assign link.reqData  = wdata_q;
  assign rdData        = rdData_q;

endmodule // light_sensor_host
`default_nettype wire

// ==== tb/light_sensor_asserts.sv ====
// concurrent checks on the link between the sensor device and its host controller
`timescale 1ns/1ps
`default_nettype none
module light_sensor_asserts (
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        rst_n,
  // request side
  input wire logic                        reqValid,
  input wire light_sensor_pkg::req_kind_e reqKind,
  input wire logic [7:0]                  reqCmd,
  input wire logic [15:0]                 reqData,
  // answer and interrupt side
  input wire logic                        rspValid,
  input wire logic                        rspAck,
  input wire logic [15:0]                 rspData,
  input wire logic                        devIntOe
);
  // shadow of the style field; word writes from the byte below are not tracked
  logic [1:0]      styleQ;
  wire logic       intCtlWr = reqValid && reqKind == light_sensor_pkg::REQ_WRITE
                              && reqCmd[7] && reqCmd[3:0] == light_sensor_pkg::ADDR_INTCTL;
  wire logic [1:0] styleD   = intCtlWr ? reqData[5:4] : styleQ;

  // style shadow register
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      styleQ <= light_sensor_pkg::STYLE_OFF;
    else
      styleQ <= styleD;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // request shapes
  sequence alertReq;
    reqValid && reqKind == light_sensor_pkg::REQ_ALERT;
  endsequence
  sequence testWr;
    intCtlWr && reqData[5:4] == light_sensor_pkg::STYLE_TEST;
  endsequence

  rsp_follow_a: assert property (reqValid |=> rspValid)
    else $error("no answer one cycle after request");
  rsp_cause_a: assert property (rspValid |-> $past(reqValid))
    else $error("answer without request");
  read_ack_a: assert property (reqValid && reqKind == light_sensor_pkg::REQ_READ && reqCmd[7] |=> rspAck)
    else $error("selected read not acknowledged");
  unsel_nack_a: assert property (reqValid && reqKind != light_sensor_pkg::REQ_ALERT && !reqCmd[7] |=> !rspAck)
    else $error("command without select bit acknowledged");
  alert_addr_a: assert property (alertReq |=> !rspAck || rspData[7:0] == {light_sensor_pkg::DEV_ADDR, 1'b0})
    else $error("alert answer lacks own address");
  alert_nack_a: assert property (alertReq ##0 !styleQ[1] |=> !rspAck)
    else $error("alert answered outside alert style");
  test_force_a: assert property (testWr |-> ##[1:3] devIntOe)
    else $error("test style did not force interrupt");
  style_off_a: assert property (styleQ == light_sensor_pkg::STYLE_OFF && $past(styleQ) == light_sensor_pkg::STYLE_OFF |-> !devIntOe)
    else $error("interrupt driven while disabled");
  int_hold_a: assert property ($fell(devIntOe) |-> $past(reqValid) || $past(reqValid, 2))
    else $error("interrupt released without a request");
endmodule // light_sensor_asserts
`default_nettype wire

// ==== tb/tb_light_sensor_threshold_interrupt.sv ====
// self-checking bench: host controller and sensor device joined by the link
`timescale 1ns/1ps
`default_nettype none
module tb_light_sensor_threshold_interrupt;
  // short integration counts keep the run brief
  localparam int SHORT_CYC = 20;
  localparam int MID_CYC   = 40;
  localparam int LONG_CYC  = 80;
  localparam int WAIT_MAX  = 200;
  localparam int MAN_GAP   = 25;
  localparam int MAN_LEN   = MAN_GAP + 9;  // nine cycles of transaction overhead

  logic        ref_clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [15:0] wrData;
  logic        wrStb;
  logic        rdStb;
  logic [15:0] rdData;
  logic [15:0] adcCh0;
  logic [15:0] adcCh1;
  logic        gainHigh;
  logic        integrating;
  logic        convDone;
  logic        ce;
  logic        ackSeen;
  int          errorCnt;
  int          checked;
  int          integCnt;

  als_link_if link ();
  light_sensor_dev #(.INTEG_SHORT_CYC(SHORT_CYC), .INTEG_MID_CYC(MID_CYC),
                     .INTEG_LONG_CYC(LONG_CYC)) i_light_sensor_dev (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .link(link), .adcCh0(adcCh0),
    .adcCh1(adcCh1), .gainHigh(gainHigh), .integrating(integrating), .convDone(convDone));
  light_sensor_host i_light_sensor_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .link(link));
  light_sensor_asserts i_light_sensor_asserts (
    .ref_clk(ref_clk), .rst_n(rst_n), .reqValid(link.reqValid), .reqKind(link.reqKind),
    .reqCmd(link.reqCmd), .reqData(link.reqData), .rspValid(link.rspValid),
    .rspAck(link.rspAck), .rspData(link.rspData), .devIntOe(link.devIntOe));

  // clock and integration length counter
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (integrating === 1'b1)
      integCnt <= integCnt + 1;

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic line(input logic e, input string n);
    chk(n, {15'h0000, e}, {15'h0000, link.intLineN});
  endtask
  // one port cycle; strobes hold until the next call so none is set twice at an edge
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wrStb <= w;
    rdStb <= r;
    addr <= a;
    wrData <= d;
    @(posedge ref_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 4'h0, 16'h0000);
  endtask
  task automatic hrd(input logic [3:0] a, output logic [15:0] v);
    bus(1'b0, 1'b1, a, 16'h0000);
    #1 v = rdData;
    idle(1);
  endtask
  // whole link transaction; busy ends two cycles after the request strobe
  task automatic xact(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] res);
    logic [15:0] st;
    bus(1'b1, 1'b0, light_sensor_pkg::HOST_WDATA, d);
    bus(1'b1, 1'b0, light_sensor_pkg::HOST_REQ, {6'h00, k, c});
    idle(3);
    hrd(light_sensor_pkg::HOST_RESULT, res);
    hrd(light_sensor_pkg::HOST_STATUS, st);
    ackSeen = st[1];
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    xact(light_sensor_pkg::REQ_WRITE, c, d, r);
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    xact(light_sensor_pkg::REQ_READ, c, 16'h0000, v);
  endtask
  task automatic alert(output logic [15:0] v);
    xact(light_sensor_pkg::REQ_ALERT, 8'h00, 16'h0000, v);
  endtask
  // cycles until the next conversion pulse, bounded
  task automatic wait_done(output int n);
    n = 0;
    do
    begin
      idle(1);
      #1 n++;
    end while (convDone !== 1'b1 && n < WAIT_MAX);
  endtask
  task automatic conv(input int k);
    int n;
    repeat (k)
    begin
      wait_done(n);
      chk("conversion seen", 16'h0001, {15'h0000, convDone});
    end
  endtask

  task automatic t_reset();
    logic [15:0] v;
    rd(8'h81, v);
    chk("timing", 16'h0002, {8'h00, v[7:0]});
    rd(8'h80, v);
    chk("control", 16'h0000, {8'h00, v[7:0]});
    rd(8'h86, v);
    chk("intctl", 16'h0000, {8'h00, v[7:0]});
    rd(8'h01, v);
    chk("unselected ack", 16'h0000, {15'h0000, ackSeen});
    line(1'b1, "line idle");
  endtask
  task automatic t_timing();
    int         n;
    logic [7:0] tv [4] = '{8'h00, 8'h01, 8'h02, 8'h11};
    int         per [4] = '{SHORT_CYC, MID_CYC, LONG_CYC, MID_CYC};
    wr(8'h80, 16'h0003);
    foreach (tv[i])
    begin
      wr(8'h81, {8'h00, tv[i]});
      wait_done(n);
      wait_done(n);
      chk("period", per[i][15:0], n[15:0]);
      chk("gain", {15'h0000, tv[i][4]}, {15'h0000, gainHigh});
    end
    // a frozen clock enable must hold the integration counter still
    ce <= 1'b0;
    idle(10);
    ce <= 1'b1;
    wait_done(n);
    chk("frozen period", MID_CYC[15:0], n[15:0]);
  endtask
  task automatic t_manual();
    int          n;
    logic [15:0] v;
    wr(8'h81, 16'h0003);
    wait_done(n);
    chk("manual stop", WAIT_MAX[15:0], n[15:0]);
    adcCh0 <= 16'h1234;
    adcCh1 <= 16'h0042;
    integCnt = 0;
    wr(8'h81, 16'h000b);
    idle(MAN_GAP);
    wr(8'h81, 16'h0003);
    wait_done(n);
    chk("manual length", MAN_LEN[15:0], integCnt[15:0]);
    rd(8'hac, v);
    chk("data0 word", 16'h1234, v);
  endtask
  task automatic t_persist();
    logic [15:0] v;
    wr(8'ha2, 16'h0100);
    wr(8'ha4, 16'h0200);
    rd(8'ha2, v);
    chk("low threshold", 16'h0100, v);
    rd(8'ha4, v);
    chk("high threshold", 16'h0200, v);
    adcCh0 <= 16'h0180;
    adcCh1 <= 16'hffff;
    wr(8'h81, 16'h0000);
    wr(8'h86, 16'h0023);
    conv(4);
    line(1'b1, "channel one ignored");
    adcCh0 <= 16'h0300;
    conv(2);
    line(1'b1, "two excursions");
    conv(1);
    idle(2);
    line(1'b0, "third excursion");
    alert(v);
    chk("alert address", {8'h00, light_sensor_pkg::DEV_ADDR, 1'b0}, {8'h00, v[7:0]});
    line(1'b1, "alert cleared");
    conv(1);
    wr(8'h86, 16'h0023);
    conv(2);
    adcCh0 <= 16'h0150;
    conv(1);
    adcCh0 <= 16'h0300;
    conv(2);
    idle(2);
    line(1'b1, "window resets count");
    conv(1);
    idle(2);
    line(1'b0, "three in a row");
    adcCh0 <= 16'h0150;
    conv(1);
    alert(v);
  endtask
  task automatic t_styles();
    logic [15:0] v;
    wr(8'h86, 16'h0011);
    adcCh0 <= 16'h0050;
    conv(1);
    idle(2);
    line(1'b0, "single excursion");
    alert(v);
    chk("alert in level", 16'h0000, {15'h0000, ackSeen});
    adcCh0 <= 16'h0150;
    conv(1);
    line(1'b0, "held until cleared");
    wr(8'hc0, 16'h0003);
    line(1'b1, "level cleared");
    conv(1);
    wr(8'h86, 16'h0010);
    conv(1);
    idle(2);
    line(1'b0, "every conversion");
    conv(1);
    wr(8'hc0, 16'h0003);
    line(1'b1, "conversion cleared");
    conv(1);
    wr(8'h86, 16'h0000);
    conv(2);
    idle(2);
    line(1'b1, "output disabled");
    wr(8'h80, 16'h0000);
    wr(8'h86, 16'h0030);
    line(1'b0, "test forced");
    alert(v);
    line(1'b1, "test cleared");
  endtask

  task automatic complete_run();
    if (errorCnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    ref_clk = 1'b0;
    ce = 1'b1;
    rst_n = 1'b0;
    addr = 4'h0;
    wrData = 16'h0000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    adcCh0 = 16'h0000;
    adcCh1 = 16'h0000;
    errorCnt = 0;
    checked = 0;
    integCnt = 0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_timing();
    t_manual();
    t_persist();
    t_styles();
    complete_run();
  end

  // watchdog: the scenarios need well under a tenth of this span
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    errorCnt++;
    complete_run();
  end
endmodule // tb_light_sensor_threshold_interrupt
`default_nettype wire
